// File: bench/color_space_stream_port_test.sv
// Purpose: Self-checking bench for the stream host with a device model
// Assumes: Identity device, so sink words equal source rows
// Notes: Inputs driven and outputs sampled at the falling edge
`timescale 1ns/1ps
`default_nettype none
module color_space_stream_port_test;
   import csc_pkg::*;
   logic         sys_clk, reset, runEnable, restartReq, srcValid, srcSof, srcEol, snkTake;
   logic         devClkEn_r, devResetN_r, srcReady_r, devInValid_r, devInUser_r, devInLast_r;
   logic         devInReady, devOutValid, devOutUser, devOutLast, devOutReady_r;
   logic         snkValid_r, snkSof_r, snkEol_r, slow, holdSink, sawBlock, pendPrev;
   logic [31:0]  devInData_r, devOutData;
   logic [34:0]  prevWord;
   csc_comp_type srcC0, srcC1, srcC2, snkC0_r, snkC1_r, snkC2_r;
   int           err_total, comparisons, inFires, n, f;
   logic [31:0]  expQ [$];
   logic [31:0]  inQ [$];
   // Rows: {eol, sof, c2, c1, c0}; identity device gives the same word back
   logic [31:0]  rows [8] = '{32'h4123_4567, 32'h3FFF_FFFF, 32'h0000_0000, 32'hBFF0_0FFF,
                              32'h0ABC_DEF0, 32'h2AAA_AAAA, 32'h1555_5555, 32'h9234_5678};
   // ==========================================
   // Design and device
   csc_stream_host dut (.sys_clk(sys_clk), .reset(reset), .runEnable(runEnable),
      .restartReq(restartReq), .devClkEn_r(devClkEn_r), .devResetN_r(devResetN_r),
      .srcValid(srcValid), .srcC0(srcC0), .srcC1(srcC1), .srcC2(srcC2), .srcSof(srcSof),
      .srcEol(srcEol), .srcReady_r(srcReady_r), .devInData_r(devInData_r),
      .devInValid_r(devInValid_r), .devInUser_r(devInUser_r), .devInLast_r(devInLast_r),
      .devInReady(devInReady), .devOutData(devOutData), .devOutValid(devOutValid),
      .devOutUser(devOutUser), .devOutLast(devOutLast), .devOutReady_r(devOutReady_r),
      .snkValid_r(snkValid_r), .snkC0_r(snkC0_r), .snkC1_r(snkC1_r), .snkC2_r(snkC2_r),
      .snkSof_r(snkSof_r), .snkEol_r(snkEol_r), .snkTake(snkTake));
   csc_dev_model devModel (.aclk(sys_clk), .clkEn(devClkEn_r), .resetN(devResetN_r),
      .slow(slow), .inData(devInData_r), .inValid(devInValid_r), .inUser(devInUser_r),
      .inLast(devInLast_r), .inReady(devInReady), .outData(devOutData),
      .outValid(devOutValid), .outUser(devOutUser), .outLast(devOutLast),
      .outReady(devOutReady_r), .externalIrqVector());
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   // ==========================================
   // Tasks
   task automatic check(input string name, input logic [34:0] seen, input logic [34:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic final_report;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   task automatic send(input logic [31:0] r);
      @(negedge sys_clk);
      srcValid = 1'b1;
      {srcEol, srcSof, srcC2, srcC1, srcC0} = r;
      while (srcReady_r !== 1'b1) begin
         sawBlock = 1'b1;
         @(negedge sys_clk);
      end
      inQ.push_back(r);
      expQ.push_back(r);
   endtask : send
   task automatic frame;
      foreach (rows[i]) send(rows[i]);
      @(negedge sys_clk);
      srcValid = 1'b0;
   endtask : frame
   task automatic drain;
      n = 0;
      while (expQ.size() > 0 && n < 600) begin
         @(negedge sys_clk);
         n++;
      end
      check("drained", expQ.size() + inQ.size(), 0);
   endtask : drain
   // ==========================================
   // Monitors
   always @(negedge sys_clk) begin
      snkTake = !holdSink;
      if (snkValid_r === 1'b1 && snkTake) begin
         if (expQ.size() == 0) check("sinkExtra", 1, 0);
         else check("sink", {snkEol_r, snkSof_r, 2'h0, snkC2_r, snkC1_r, snkC0_r},
                    {expQ[0][31:30], 2'h0, expQ[0][29:0]});
         if (expQ.size() > 0) void'(expQ.pop_front());
      end
      if (pendPrev) check("inHold", {devInValid_r, devInLast_r, devInUser_r, devInData_r},
                          prevWord);
      pendPrev = devInValid_r === 1'b1;
      prevWord = {devInValid_r, devInLast_r, devInUser_r, devInData_r};
      if ((devInValid_r & devInReady & devClkEn_r & devResetN_r) === 1'b1) begin
         pendPrev = 1'b0;
         inFires++;
         if (inQ.size() == 0) check("devInExtra", 1, 0);
         else check("devIn", {devInLast_r, devInUser_r, devInData_r},
                    {inQ[0][31:30], 2'h0, inQ[0][29:0]});
         if (inQ.size() > 0) void'(inQ.pop_front());
      end
   end
   initial begin
      #400000;
      err_total++;
      final_report();
   end
   // ==========================================
   // Sequence
   initial begin
      {err_total, comparisons, inFires} = '0;
      {reset, runEnable, restartReq, srcValid, srcSof, srcEol, slow, holdSink} = 8'h80;
      {srcC0, srcC1, srcC2} = '0;
      {snkTake, sawBlock, pendPrev} = 3'h0;
      prevWord = '0;
      runEnable = 1'b1;
      repeat (16) @(negedge sys_clk);
      check("rstOut", {devClkEn_r, devResetN_r, srcReady_r, devOutReady_r, devInValid_r,
                       snkValid_r}, 6'h0C);
      reset = 1'b0;
      n = 0;
      while (devResetN_r !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      check("rstHold", n, 32);
      check("clkEn", devClkEn_r, 1);
      frame();
      drain();
      // Sink stalls while the device input limps
      holdSink = 1'b1;
      slow = 1'b1;
      fork
         begin
            frame();
            frame();
         end
         begin
            repeat (60) @(negedge sys_clk);
            holdSink = 1'b0;
         end
      join
      drain();
      check("backPressure", sawBlock, 1);
      slow = 1'b0;
      // Enable pause in mid-frame
      fork
         frame();
         begin
            repeat (3) @(negedge sys_clk);
            runEnable = 1'b0;
            repeat (2) @(negedge sys_clk);
            f = inFires;
            check("pauseEn", devClkEn_r, 0);
            repeat (12) @(negedge sys_clk);
            check("pauseFires", inFires, f);
            runEnable = 1'b1;
         end
      join
      drain();
      // Device restart while idle, then a fresh frame
      @(negedge sys_clk);
      restartReq = 1'b1;
      @(negedge sys_clk);
      restartReq = 1'b0;
      check("restartLow", devResetN_r, 0);
      n = 0;
      while (devResetN_r !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      check("restartHold", n >= 32 && n < 34, 1);
      frame();
      drain();
      final_report();
   end
endmodule : color_space_stream_port_test
`default_nettype wire

// File: bench/csc_dev_model.sv
// Purpose: Behavioural colour-space device seen from the stream side
// Assumes: Identity conversion, fixed latency, queue of DEPTH pixels
// Notes: slow drops input ready every other enabled cycle
`timescale 1ns/1ps
`default_nettype none
module csc_dev_model #(
   parameter int LAT   = 9,
   parameter int DEPTH = 12
) (
   // Core clock, enable, reset, slow mode
   input  wire logic        aclk,
   input  wire logic        clkEn,
   input  wire logic        resetN,
   input  wire logic        slow,
   // Input stream
   input  wire logic [31:0] inData,
   input  wire logic        inValid,
   input  wire logic        inUser,
   input  wire logic        inLast,
   output var  logic        inReady,
   // Output stream
   output var  logic [31:0] outData,
   output var  logic        outValid,
   output var  logic        outUser,
   output var  logic        outLast,
   input  wire logic        outReady,
   // Interrupt side
   output wire logic [5:0]  externalIrqVector
);
   logic [33:0] pipeQ [$];
   int          ageQ [$];
   logic        phase;
   // ==========================================
   // Pipeline
   initial begin
      {inReady, outValid, outUser, outLast, phase} = 5'h00;
      outData = 32'h0000_0000;
   end
   // Interrupt option built in, no source raised
   assign externalIrqVector = 6'h00;
   always @(posedge aclk) begin
      if (!resetN) begin
         pipeQ.delete();
         ageQ.delete();
         inReady  <= 1'b0;
         outValid <= 1'b0;
      end else if (clkEn) begin
         if (outValid && outReady) begin
            void'(pipeQ.pop_front());
            void'(ageQ.pop_front());
         end
         foreach (ageQ[i]) ageQ[i]++;
         if (inValid && inReady) begin
            pipeQ.push_back({inLast, inUser, inData});
            ageQ.push_back(0);
         end
         phase = !phase;
         inReady <= (pipeQ.size() < DEPTH) && !(slow && phase);
         if (pipeQ.size() > 0 && ageQ[0] >= LAT) begin
            outValid          <= 1'b1;
            outData           <= {2'h0, pipeQ[0][29:0]};
            {outLast, outUser} <= pipeQ[0][33:32];
         end else begin
            outValid          <= 1'b0;
            outData           <= ~outData;
            {outLast, outUser} <= ~{outLast, outUser};
         end
      end
   end
endmodule : csc_dev_model
`default_nettype wire

// File: core/csc_reset_seq.sv
// Purpose: Drives the device core reset, low for a fixed count
// Assumes: Host reset is synchronous active high
// Notes: Restart request re-enters the hold phase
`timescale 1ns/1ps
`default_nettype none
`include "csc_params.svh"
module csc_reset_seq (
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               reset,
   // Control
   input  wire logic               restartReq,
   // Device reset
   output var  logic               devResetN_r
);
   import csc_pkg::*;
   // ==========================================================
   // Hold sequencer
   csc_rst_state_type state_r;
   csc_rst_state_type state_nxt;
   csc_rst_cnt_type   count_r;
   csc_rst_cnt_type   count_nxt;
   logic              devResetN_nxt;

   always_comb begin
      state_nxt     = state_r;
      count_nxt     = count_r;
      devResetN_nxt = devResetN_r;
      case (state_r)
         RST_HOLD: begin
            count_nxt = count_r + 6'h01;
            if (count_r == `CSC_RST_HOLD_CYC - 6'h01) begin
               state_nxt     = RST_RUN;
               devResetN_nxt = 1'h1;
            end
         end
         RST_RUN: begin
            if (restartReq) begin
               state_nxt     = RST_HOLD;
               count_nxt     = 6'h00;
               devResetN_nxt = 1'h0;
            end
         end
         default: begin
            state_nxt     = RST_HOLD;
            count_nxt     = 6'h00;
            devResetN_nxt = 1'h0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_r     <= RST_HOLD;
         count_r     <= 6'h00;
         devResetN_r <= 1'h0;
      end else begin
         state_r     <= state_nxt;
         count_r     <= count_nxt;
         devResetN_r <= devResetN_nxt;
      end
   end

   // ==========================================================
   // Checks
   logic [7:0] lowCnt_r;
   always_ff @(posedge sys_clk) begin
      if (reset || devResetN_r) begin
         lowCnt_r <= 8'h00;
      end else if (lowCnt_r != 8'hFF) begin
         lowCnt_r <= lowCnt_r + 8'h01;
      end
   end

   AST_RESET_LEN: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(devResetN_r) |-> $past(lowCnt_r) >= {2'h0, `CSC_RST_HOLD_CYC - 6'h01})
      else $error("device reset released too early");
   AST_RESTART_LOW: assert property (@(posedge sys_clk) disable iff (reset)
      (devResetN_r && restartReq) |=> !devResetN_r [*8])
      else $error("restart did not hold device reset low");
   COV_RESTART: cover property (@(posedge sys_clk) disable iff (reset)
      devResetN_r && restartReq);
endmodule : csc_reset_seq
`default_nettype wire

// File: core/csc_stream_host.sv
// Purpose: Host that feeds and drains the colour-space converter streams
// Assumes: Device stream pins are synchronous to sys_clk
// Notes: Two-entry slices on both sides keep every ready registered
`timescale 1ns/1ps
`default_nettype none
`include "csc_params.svh"
module csc_stream_host (
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   // Device control
   input  wire logic                   runEnable,
   input  wire logic                   restartReq,
   output var  logic                   devClkEn_r,
   output wire logic                   devResetN_r,
   // User pixel source
   input  wire logic                   srcValid,
   input  wire csc_pkg::csc_comp_type  srcC0,
   input  wire csc_pkg::csc_comp_type  srcC1,
   input  wire csc_pkg::csc_comp_type  srcC2,
   input  wire logic                   srcSof,
   input  wire logic                   srcEol,
   output var  logic                   srcReady_r,
   // Device input stream
   output wire logic [`CSC_WORD_W-1:0] devInData_r,
   output wire logic                   devInValid_r,
   output wire logic                   devInUser_r,
   output wire logic                   devInLast_r,
   input  wire logic                   devInReady,
   // Device output stream
   input  wire logic [`CSC_WORD_W-1:0] devOutData,
   input  wire logic                   devOutValid,
   input  wire logic                   devOutUser,
   input  wire logic                   devOutLast,
   output var  logic                   devOutReady_r,
   // User pixel sink
   output wire logic                   snkValid_r,
   output wire csc_pkg::csc_comp_type  snkC0_r,
   output wire csc_pkg::csc_comp_type  snkC1_r,
   output wire csc_pkg::csc_comp_type  snkC2_r,
   output wire logic                   snkSof_r,
   output wire logic                   snkEol_r,
   input  wire logic                   snkTake
);
   import csc_pkg::*;

   // ==========================================================
   // Helpers
   function automatic csc_beat_type packBeat(input csc_comp_type c0, input csc_comp_type c1,
                                             input csc_comp_type c2, input logic sof,
                                             input logic eol);
      csc_beat_type b;
      b = '0;
      b[`CSC_C0_LSB +: `CSC_COMP_W] = c0;
      b[`CSC_C1_LSB +: `CSC_COMP_W] = c1;
      b[`CSC_C2_LSB +: `CSC_COMP_W] = c2;
      b[`CSC_PAD_LSB +: `CSC_PAD_W] = '0;
      b[`CSC_SOF_BIT] = sof;
      b[`CSC_EOL_BIT] = eol;
      packBeat = b;
   endfunction : packBeat

   // Two-entry slice step: {mainV, main, skidV, skid}
   function automatic logic [`CSC_STEP_W-1:0] skidStep(input logic mainV, input csc_beat_type main,
                                                      input logic skidV, input csc_beat_type skid,
                                                      input logic inFire, input csc_beat_type inBeat,
                                                      input logic outFire);
      logic         mv;
      logic         sv;
      csc_beat_type m;
      csc_beat_type s;
      mv = mainV;
      sv = skidV;
      m  = main;
      s  = skid;
      if (outFire) begin
         if (skidV) begin
            m  = skid;
            sv = inFire;
            if (inFire) begin
               s = inBeat;
            end
         end else if (inFire) begin
            m = inBeat;
         end else begin
            mv = 1'h0;
         end
      end else if (inFire) begin
         if (!mainV) begin
            m  = inBeat;
            mv = 1'h1;
         end else begin
            s  = inBeat;
            sv = 1'h1;
         end
      end
      skidStep = {mv, m, sv, s};
   endfunction : skidStep

   // ==========================================================
   // Device reset and enable
   logic devClkEn_nxt;

   csc_reset_seq uResetSeq (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .restartReq  (restartReq),
      .devResetN_r (devResetN_r)
   );

   always_comb begin
      devClkEn_nxt = runEnable;
   end

   // ==========================================================
   // Source slice toward the device
   logic         srcMainV_r;
   logic         srcMainV_nxt;
   csc_beat_type srcMain_r;
   csc_beat_type srcMain_nxt;
   logic         srcSkidV_r;
   logic         srcSkidV_nxt;
   csc_beat_type srcSkid_r;
   csc_beat_type srcSkid_nxt;
   logic         srcReady_nxt;
   logic         userFire;
   logic         devFire;

   always_comb begin
      userFire = srcValid & srcReady_r;
      devFire  = beatFire(devInValid_r, devInReady, devClkEn_r, devResetN_r);
      // Main entry moves only on a completed beat
      {srcMainV_nxt, srcMain_nxt, srcSkidV_nxt, srcSkid_nxt} =
         skidStep(srcMainV_r, srcMain_r, srcSkidV_r, srcSkid_r, userFire,
                  packBeat(srcC0, srcC1, srcC2, srcSof, srcEol), devFire);
      srcReady_nxt = !srcSkidV_nxt;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         devClkEn_r <= 1'h0;
         srcMainV_r <= 1'h0;
         srcMain_r  <= '0;
         srcSkidV_r <= 1'h0;
         srcSkid_r  <= '0;
         srcReady_r <= 1'h1;
      end else begin
         devClkEn_r <= devClkEn_nxt;
         srcMainV_r <= srcMainV_nxt;
         srcMain_r  <= srcMain_nxt;
         srcSkidV_r <= srcSkidV_nxt;
         srcSkid_r  <= srcSkid_nxt;
         srcReady_r <= srcReady_nxt;
      end
   end

   assign devInValid_r = srcMainV_r;
   assign devInData_r  = srcMain_r[`CSC_WORD_W-1:0];
   assign devInUser_r  = srcMain_r[`CSC_SOF_BIT];
   assign devInLast_r  = srcMain_r[`CSC_EOL_BIT];

   // ==========================================================
   // Sink slice from the device
   logic         snkMainV_r;
   logic         snkMainV_nxt;
   csc_beat_type snkMain_r;
   csc_beat_type snkMain_nxt;
   logic         snkSkidV_r;
   logic         snkSkidV_nxt;
   csc_beat_type snkSkid_r;
   csc_beat_type snkSkid_nxt;
   logic         devOutReady_nxt;
   logic         sinkFire;
   logic         takeFire;
   csc_beat_type devOutBeat;

   always_comb begin
      sinkFire   = beatFire(devOutValid, devOutReady_r, devClkEn_r, devResetN_r);
      takeFire   = snkMainV_r & snkTake;
      devOutBeat = {devOutLast, devOutUser, devOutData};
      {snkMainV_nxt, snkMain_nxt, snkSkidV_nxt, snkSkid_nxt} =
         skidStep(snkMainV_r, snkMain_r, snkSkidV_r, snkSkid_r, sinkFire, devOutBeat, takeFire);
      devOutReady_nxt = !snkSkidV_nxt;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         snkMainV_r    <= 1'h0;
         snkMain_r     <= '0;
         snkSkidV_r    <= 1'h0;
         snkSkid_r     <= '0;
         devOutReady_r <= 1'h1;
      end else begin
         snkMainV_r    <= snkMainV_nxt;
         snkMain_r     <= snkMain_nxt;
         snkSkidV_r    <= snkSkidV_nxt;
         snkSkid_r     <= snkSkid_nxt;
         devOutReady_r <= devOutReady_nxt;
      end
   end

   // Padding bits are dropped on unpacking
   assign snkValid_r = snkMainV_r;
   assign snkC0_r    = snkMain_r[`CSC_C0_LSB +: `CSC_COMP_W];
   assign snkC1_r    = snkMain_r[`CSC_C1_LSB +: `CSC_COMP_W];
   assign snkC2_r    = snkMain_r[`CSC_C2_LSB +: `CSC_COMP_W];
   assign snkSof_r   = snkMain_r[`CSC_SOF_BIT];
   assign snkEol_r   = snkMain_r[`CSC_EOL_BIT];

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   AST_HOLD_STABLE: assert property (
      (devInValid_r && !devFire) |=> $stable(devInData_r) && $stable(devInUser_r) && $stable(devInLast_r))
      else $error("source word changed before completion");
   AST_NO_WITHDRAW: assert property (
      (devInValid_r && !devFire) |=> devInValid_r)
      else $error("source valid withdrawn");
   AST_PAD_ZERO: assert property (
      devInValid_r |-> devInData_r[`CSC_PAD_LSB +: `CSC_PAD_W] == '0)
      else $error("padding bits not zero");
   AST_ENABLE_HOLD: assert property (
      (!devClkEn_r && devInValid_r) ##1 devInValid_r |-> $stable(devInData_r))
      else $error("beat moved while enable low");
   AST_VALID_NOT_WAIT: assert property (
      (userFire && !devInValid_r) |=> devInValid_r && devInUser_r == $past(srcSof))
      else $error("valid waited or flag lost");
   AST_SINK_READY: assert property (
      !snkMainV_r |-> devOutReady_r)
      else $error("sink ready low while empty");
   AST_SOF_CARRY: assert property (
      (sinkFire && !snkMainV_r) |=> snkValid_r && snkSof_r == $past(devOutUser))
      else $error("start of frame not carried");
   AST_EOL_CARRY: assert property (
      (sinkFire && !snkMainV_r) |=> snkValid_r && snkEol_r == $past(devOutLast))
      else $error("end of line not carried");
   AST_SINK_HOLD: assert property (
      (snkValid_r && !snkTake) |=> snkValid_r && $stable(snkC0_r))
      else $error("sink pixel lost");

   COV_BACK_TO_BACK: cover property (devFire ##1 devFire ##1 devFire);
   COV_SINK_STALL: cover property (devOutValid && !devOutReady_r);
   COV_SOF_BEAT: cover property (devFire && devInUser_r);
   COV_ENABLE_LOW: cover property (!devClkEn_r && devInValid_r && devInReady);
endmodule : csc_stream_host
`default_nettype wire

// File: pkg/csc_params.svh
// Purpose: Constants for the colour-space stream port host controller
// Assumes: One core clock, 10-bit components packed into a 32-bit word
// Notes: Included by the package and by the design modules
//
// Notes on behaviour
// - Host drives device reset synchronously and holds it low 32 cycles or more.
// - Host packs pixels into 24-48 bit words, zero-padding the top bits.
// - A beat moves only when ready, valid, enable and reset-low-inactive are high.
// - Only active picture pixels travel; no blanking or ancillary data.
// - Source holds all signals steady from valid until the beat completes.
// - Source never drops valid before the pending beat completes.
// - Sink ready may come before, with or after valid; valid never waits.
// - Sink should drive ready independently or registered after valid.
// - Sideband bit 0 marks first pixel of a frame for one beat.
// - Start-of-frame may rise early only while valid stays low.
// - Last sideband marks final pixel of each line for one beat.
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH
`define CSC_COMP_W       10
`define CSC_WORD_W       32
`define CSC_PAD_W        2
`define CSC_C0_LSB       0
`define CSC_C1_LSB       10
`define CSC_C2_LSB       20
`define CSC_PAD_LSB      30
`define CSC_SOF_BIT      32
`define CSC_EOL_BIT      33
`define CSC_BEAT_W       34
`define CSC_STEP_W       70
`define CSC_RST_HOLD_CYC 6'h20
`define CSC_RST_CNT_W    6
`endif

// File: pkg/csc_pkg.sv
// Purpose: Types and helpers for the stream port host controller
// Assumes: Constants come from csc_params.svh
// Notes: No timescale in a package
`include "csc_params.svh"
package csc_pkg;
   typedef enum logic [0:0] {
      RST_HOLD = 1'h0,
      RST_RUN  = 1'h1
   } csc_rst_state_type;
   typedef logic [`CSC_COMP_W-1:0] csc_comp_type;
   typedef logic [`CSC_BEAT_W-1:0] csc_beat_type;
   typedef logic [`CSC_RST_CNT_W-1:0] csc_rst_cnt_type;
   // Beat completion test
   function automatic logic beatFire(input logic valid, input logic ready,
                                     input logic clkEn, input logic resetN);
      beatFire = valid & ready & clkEn & resetN;
   endfunction : beatFire
endpackage : csc_pkg
